// File: logic/mrs_top.sv
// Startup sequencer and serial record framer with a Wishbone register file.
// Assumes synchronous inputs; porn is a power-on reset that only the
// battery-backed settings see, so a computer reset keeps them.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
module mrs_top
    import mrs_pkg::*;
#(
    parameter int NV_BYTES = NV_BYTES_DEF,
    parameter logic [39:0] SPAN_CYC = SPAN_CYC_DEF,
    parameter longint CLK_FREQ = CLK_HZ
)(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic porn,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic txd,
    output logic [3:0] ana_status,
    output logic calib_busy,
    output logic [1:0] run_seq,
    output logic host_mode
);
    if (NV_BYTES < 4 || SPAN_CYC == 40'h0)
        $error("mrs_top: storage or span length too small");
    if (CLK_FREQ / BAUD_RATE[N_BAUD - 1] < 2 ||
        CLK_FREQ / BAUD_RATE[0] >= 262144)
        $error("mrs_top: clock rate cannot serve the serial rates");

    // Bit-time divisors, one per selectable rate.
    localparam logic [17:0] DIV_TBL [N_BAUD] = '{
        18'(CLK_FREQ / BAUD_RATE[0]), 18'(CLK_FREQ / BAUD_RATE[1]),
        18'(CLK_FREQ / BAUD_RATE[2]), 18'(CLK_FREQ / BAUD_RATE[3]),
        18'(CLK_FREQ / BAUD_RATE[4]), 18'(CLK_FREQ / BAUD_RATE[5])};

    logic host_r, host_nxt, span_r, span_nxt;
    logic [1:0] seq_r, seq_nxt;
    logic [2:0] baud_r, baud_nxt;
    logic ack_r, ack_nxt, drop_r, drop_nxt, txd_r, txd_nxt;
    logic [31:0] dat_r, dat_nxt, m;
    logic [31:0] f_r [8];
    logic [31:0] f_nxt [8];
    mrs_seq_t q_r, q_nxt;
    mrs_fmt_t s_r, s_nxt;
    logic [39:0] cnt_r, cnt_nxt;
    logic [2:0] fi_r, fi_nxt, ni_r, ni_nxt;
    logic lead_r, lead_nxt, wr, legal, emit, idle, load;
    logic [3:0] nib, bits_r, bits_nxt, ana_r, ana_nxt;
    logic [7:0] ch, ldch;
    logic [8:0] sh_r, sh_nxt;
    logic [17:0] div_r, div_nxt;
    logic [1:0] run_r, run_nxt;

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign txd = txd_r;
    assign ana_status = ana_r;
    assign calib_busy = (q_r == Q_SPAN);
    assign run_seq = run_r;
    assign host_mode = host_r;

    // Bus decode, settings and field registers. Writes take effect at the
    // edge that raises ack, so every access answers after one cycle.
    always_comb
    begin
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        wr = ack_nxt & wb_we_i;
        m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        host_nxt = host_r;
        span_nxt = span_r;
        seq_nxt = seq_r;
        baud_nxt = baud_r;
        f_nxt = f_r;
        dat_nxt = 32'h0;
        if (wr && wb_sel_i[0] && wb_adr_i == OFS_CTRL)
        begin
            host_nxt = wb_dat_i[CT_HOST];
            span_nxt = wb_dat_i[CT_SPAN];
            if (wb_dat_i[CT_SEQ +: 2] != 2'h0)
                seq_nxt = wb_dat_i[CT_SEQ +: 2];
            if (wb_dat_i[CT_BAUD +: 3] < 3'(N_BAUD))
                baud_nxt = wb_dat_i[CT_BAUD +: 3];
        end
        if (wr && wb_sel_i[0] && wb_adr_i == OFS_CMD)
        begin
            if (wb_dat_i[CM_STAND])
                host_nxt = 1'b0;
            else if (wb_dat_i[CM_HOST])
                host_nxt = 1'b1;
        end
        for (int i = 0; i < 8; i++)
            if (wr && wb_adr_i == OFS_FLD + 8'(4 * i))
                f_nxt[i] = (f_r[i] & ~m) | (wb_dat_i & m);
        if (ack_nxt && !wb_we_i)
        begin
            if (wb_adr_i == OFS_CTRL)
                dat_nxt = {25'h0, baud_r, seq_r, span_r, host_r};
            else if (wb_adr_i == OFS_STAT)
                dat_nxt = {20'h0, ana_r, 3'h0, drop_r, run_r,
                           q_r == Q_SPAN, s_r != F_IDLE};
            else
                for (int i = 0; i < 8; i++)
                    if (wb_adr_i == OFS_FLD + 8'(4 * i))
                        dat_nxt = f_r[i];
        end
    end

    // Sequencer, record framer and serial transmitter.
    always_comb
    begin
        q_nxt = q_r;
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        s_nxt = s_r;
        fi_nxt = fi_r;
        ni_nxt = ni_r;
        lead_nxt = lead_r;
        drop_nxt = drop_r;
        sh_nxt = sh_r;
        bits_nxt = bits_r;
        div_nxt = div_r;
        txd_nxt = txd_r;
        load = 1'b0;
        ldch = 8'h0;
        idle = (bits_r == 4'h0);
        // Legal record codes; 7 is analog-only and is refused here.
        legal = (f_r[0][3:0] != 4'h0 && f_r[0][3:0] < ST_CAL) ||
                f_r[0][3:0] == ST_FOG;
        nib = f_r[fi_r][4 * ni_r +: 4];
        ch = (nib <= 4'h9) ? 8'h30 + 8'(nib) :
             (nib == 4'hA) ? 8'h2E : (nib == 4'hB) ? 8'h2D : 8'h0;
        // Leading zeros are dropped so that fields print as plain numbers.
        emit = ch != 8'h0 && !(nib == 4'h0 && !lead_r && ni_r != 3'h0);
        unique case (q_r)
            Q_START:
            begin
                q_nxt = span_r ? Q_SPAN : Q_RUN;
                cnt_nxt = 40'h0;
            end
            Q_SPAN:
            begin
                cnt_nxt = cnt_r + 40'h1;
                if (cnt_r == SPAN_CYC - 40'h1)
                    q_nxt = Q_RUN;
            end
            Q_RUN:
                run_nxt = seq_r;
        endcase
        if (wr && wb_adr_i == OFS_CMD && wb_sel_i[0] && wb_dat_i[CM_RUN])
        begin
            q_nxt = Q_START;
            run_nxt = 2'h0;
        end
        if (wr && wb_adr_i == OFS_STAT && wb_sel_i[0] && wb_dat_i[SR_DROP])
            drop_nxt = 1'b0;
        unique case (s_r)
            F_IDLE:
                if (wr && wb_adr_i == OFS_CMD && wb_sel_i[0] &&
                    wb_dat_i[CM_SEND])
                begin
                    if (legal)
                    begin
                        s_nxt = F_DIG;
                        fi_nxt = 3'h0;
                        ni_nxt = 3'h0; // Status is a single digit.
                        lead_nxt = 1'b0;
                    end
                    else
                        drop_nxt = 1'b1;
                end
            F_DIG:
                if (!emit || idle)
                begin
                    load = emit;
                    ldch = ch;
                    lead_nxt = lead_r | emit;
                    ni_nxt = ni_r - 3'h1;
                    if (ni_r == 3'h0)
                        s_nxt = (fi_r == 3'h7 || f_r[0][3:0] == ST_RAIN) ?
                                F_CR : F_SEP;
                end
            F_SEP:
                if (idle)
                begin
                    load = 1'b1;
                    ldch = 8'h20;
                    fi_nxt = fi_r + 3'h1;
                    ni_nxt = 3'h7;
                    lead_nxt = 1'b0;
                    s_nxt = F_DIG;
                end
            F_CR:
                if (idle)
                begin
                    load = 1'b1;
                    ldch = 8'h0D;
                    s_nxt = F_LF;
                end
            F_LF:
                if (idle)
                begin
                    load = 1'b1;
                    ldch = 8'h0A;
                    s_nxt = F_IDLE;
                end
            default:
                s_nxt = F_IDLE;
        endcase
        // The divisor is reloaded from baud_r at every bit, so a rate change
        // takes effect inside a character.
        if (load)
        begin
            sh_nxt = {1'b1, ldch};
            bits_nxt = UART_BITS;
            div_nxt = DIV_TBL[baud_r] - 18'h1;
            txd_nxt = 1'b0;
        end
        else if (!idle)
        begin
            div_nxt = div_r - 18'h1;
            if (div_r == 18'h0)
            begin
                div_nxt = DIV_TBL[baud_r] - 18'h1;
                bits_nxt = bits_r - 4'h1;
                txd_nxt = sh_r[0];
                sh_nxt = {1'b1, sh_r[8:1]};
            end
        end
        // The analog channel shows 7 throughout calibration.
        ana_nxt = (q_r == Q_SPAN) ? ST_CAL :
                  (s_r == F_IDLE && s_nxt == F_DIG) ? f_r[0][3:0] : ana_r;
    end

    // Persistent settings: set to their reset values only at power-on, kept across rstn.
    always_ff @(posedge mclk or negedge porn)
    begin
        if (!porn)
        begin
            host_r <= HOST_RST;
            span_r <= SPAN_RST;
            seq_r <= SEQ_RST;
            baud_r <= BAUD_RST;
        end
        else if (ce)
        begin
            host_r <= host_nxt;
            span_r <= span_nxt;
            seq_r <= seq_nxt;
            baud_r <= baud_nxt;
        end
    end

    // Working state of bus, sequencer, framer and transmitter.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
            f_r <= '{default: 32'h0};
            q_r <= Q_START;
            cnt_r <= 40'h0;
            run_r <= 2'h0;
            s_r <= F_IDLE;
            fi_r <= 3'h0;
            ni_r <= 3'h0;
            lead_r <= 1'b0;
            drop_r <= 1'b0;
            sh_r <= 9'h1FF;
            bits_r <= 4'h0;
            div_r <= 18'h0;
            txd_r <= 1'b1;
            ana_r <= 4'h0;
        end
        else if (ce)
        begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            f_r <= f_nxt;
            q_r <= q_nxt;
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            s_r <= s_nxt;
            fi_r <= fi_nxt;
            ni_r <= ni_nxt;
            lead_r <= lead_nxt;
            drop_r <= drop_nxt;
            sh_r <= sh_nxt;
            bits_r <= bits_nxt;
            div_r <= div_nxt;
            txd_r <= txd_nxt;
            ana_r <= ana_nxt;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn || !porn);

    sequence rec_end_cr;
        s_r == F_DIG && ni_r == 3'h0 && (!emit || idle);
    endsequence

    a_ack_single: assert property (ce && ack_r |=> !ack_r)
        else $error("ack held beyond one cycle");
    a_no_code7: assert property (s_r == F_IDLE ##1 s_r == F_DIG
        |-> f_r[0][3:0] != ST_CAL && f_r[0][3:0] != 4'h0)
        else $error("record started with illegal status");
    a_seq_legal: assert property (seq_r != 2'h0)
        else $error("stored sequence out of range");
    a_span_skip: assert property (ce && q_r == Q_START && !span_r
        |=> q_r == Q_RUN)
        else $error("span not skipped with flag clear");
    a_span_run: assert property (ce && q_r == Q_START && span_r
        |=> q_r == Q_SPAN)
        else $error("span not entered with flag set");
    a_ana_cal: assert property (ce && q_r == Q_SPAN |=> ana_r == ST_CAL)
        else $error("analog status not 7 during span");
    a_field_step: assert property (ce && s_r == F_SEP && idle
        |=> fi_r == $past(fi_r) + 3'h1)
        else $error("record fields out of order");
    a_rain_short: assert property ((rec_end_cr and (ce && fi_r == 3'h0 &&
        f_r[0][3:0] == ST_RAIN)) |=> s_r == F_CR)
        else $error("rain record not ended after status");
    a_start_bit: assert property (ce && load |=> !txd_r && bits_r == 4'hA)
        else $error("character not framed with start bit");
    a_mode_cmd: assert property (ce && wr && wb_adr_i == OFS_CMD &&
        wb_sel_i[0] && wb_dat_i[CM_STAND] |=> !host_r)
        else $error("standalone command ignored");
endmodule

// File: logic/mrs_pkg.sv
// Constants for the measurement record sequencer.
// Assumes a single 40 MHz system clock and a 32-bit Wishbone register bus.
package mrs_pkg;
    // Clock rate and the length of the startup span calibration.
    localparam longint CLK_HZ = 40_000_000;
    localparam longint SPAN_MIN = 20;
    localparam logic [39:0] SPAN_CYC_DEF = 40'(SPAN_MIN * 60 * CLK_HZ);
    localparam int NV_BYTES_DEF = 50;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_FLD = 8'h20;
    // Field positions in CTRL, CMD and STAT.
    localparam int CT_HOST = 0;
    localparam int CT_SPAN = 1;
    localparam int CT_SEQ = 2;
    localparam int CT_BAUD = 4;
    localparam int CM_RUN = 0;
    localparam int CM_STAND = 1;
    localparam int CM_HOST = 2;
    localparam int CM_SEND = 3;
    localparam int SR_BUSY = 0;
    localparam int SR_SPAN = 1;
    localparam int SR_SEQ = 2;
    localparam int SR_DROP = 4;
    localparam int SR_ANA = 8;
    // Reset values of the persistent settings.
    localparam logic HOST_RST = 1'b0;
    localparam logic SPAN_RST = 1'b1;
    localparam logic [1:0] SEQ_RST = 2'h1;
    localparam logic [2:0] BAUD_RST = 3'h5;
    // Status codes carried in records and on the analog status channel.
    localparam logic [3:0] ST_RAIN = 4'h5;
    localparam logic [3:0] ST_CAL = 4'h7;
    localparam logic [3:0] ST_FOG = 4'h8;
    // Selectable serial rates; divisors follow from the module's clock.
    localparam int N_BAUD = 6;
    localparam longint BAUD_RATE [N_BAUD] = '{
        300, 600, 1200, 2400, 4800, 9600};
    localparam logic [3:0] UART_BITS = 4'hA;
    typedef enum logic [1:0] {Q_START, Q_SPAN, Q_RUN} mrs_seq_t;
    typedef enum logic [2:0] {F_IDLE, F_DIG, F_SEP, F_CR, F_LF} mrs_fmt_t;
endpackage

// File: test/mrs_capture.sv
// Serial capture model standing in for the printer or data logger.
// Assumes the line idles high and the bit time is given in clock cycles.
module mrs_capture #(
    parameter int BIT_CYC = 4166
)(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic rxd,
    output logic [7:0] rx_byte,
    output logic rx_stb,
    output logic frame_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] bitn;
    logic [15:0] cnt;
    logic [7:0] sh;

    // Samples each bit at its centre, LSB first, 8N1 like a real logger.
    // A low stop bit is remembered rather than resynchronised on.
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy <= 1'b0;
            rx_stb <= 1'b0;
            frame_err <= 1'b0;
        end
        else
        begin
            rx_stb <= 1'b0;
            if (!busy)
            begin
                busy <= !rxd;
                cnt <= 16'(BIT_CYC / 2);
                bitn <= 4'h0;
            end
            else if (cnt != 16'h0)
                cnt <= cnt - 16'h1;
            else
            begin
                cnt <= 16'(BIT_CYC - 1);
                bitn <= bitn + 4'h1;
                sh <= {rxd, sh[7:1]};
                if (bitn == 4'h9)
                begin
                    busy <= 1'b0;
                    frame_err <= frame_err | !rxd;
                    rx_stb <= 1'b1;
                    rx_byte <= sh;
                end
            end
        end
    end
endmodule

// File: test/mrs_top_tb.sv
// Self-checking bench for the record sequencer: settings, startup, records.
// Assumes the capture model on txd and a shortened span calibration.
module mrs_top_tb import mrs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SPAN = 100;
    localparam int BITC = 16;
    logic mclk = 1'b0, rstn = 1'b0, porn = 1'b0, ce = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic ack, txd, host, busy, rx_stb, ferr;
    logic [3:0] ana, st;
    logic [1:0] rseq, sq;
    logic [7:0] rx_byte;
    logic [7:0] rxq [$];
    logic [3:0] ok_st [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
    logic [31:0] cmds [3] = '{32'h4, 32'h2, 32'h6};
    int n_mismatch = 0;
    int checks = 0;
    int d;

    // Free-running 40 MHz clock.
    always #12.5 mclk = ~mclk;

    // The clock rate is scaled so that a 9600 baud bit lasts BITC cycles.
    mrs_top #(.SPAN_CYC(40'(SPAN)), .CLK_FREQ(BITC * 9600)) u_dut (
        .mclk(mclk), .rstn(rstn), .porn(porn), .ce(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .txd(txd), .ana_status(ana), .calib_busy(busy), .run_seq(rseq),
        .host_mode(host));

    mrs_capture #(.BIT_CYC(BITC)) u_cap (.mclk(mclk), .rstn(rstn),
        .rxd(txd), .rx_byte(rx_byte), .rx_stb(rx_stb), .frame_err(ferr));

    // Every captured character is queued for the checks below.
    always @(posedge mclk)
        if (rx_stb === 1'b1)
            rxq.push_back(rx_byte);

    function automatic logic [31:0] ctrl_w(input logic h, input logic s,
        input logic [1:0] q, input logic [2:0] b);
        return {25'h0, b, q, s, h};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h, expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One classic Wishbone cycle; read data is taken at the ack edge.
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] v);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        do
            @(posedge mclk);
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // A power-on reset also returns the stored settings to their reset values.
    task automatic do_reset(input logic pw);
        @(posedge mclk);
        rstn <= 1'b0;
        porn <= ~pw;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        porn <= 1'b1;
    endtask

    // Sends the stored record and waits for n characters to arrive.
    task automatic send_rec(input int n);
        rxq.delete();
        wb(1'b1, OFS_CMD, 32'h8);
        while (rxq.size() < n)
            @(posedge mclk);
    endtask

    // Main sequence; a full record at 9600 baud is far too long, so
    // only the first characters of the last one are looked at.
    initial
    begin
        void'($urandom(73613));
        do_reset(1'b1);
        repeat (5) @(posedge mclk);
        check(busy, 1'b1);
        check(ana, 4'h7);
        ce <= 1'b0;
        repeat (SPAN) @(posedge mclk);
        check(busy, 1'b1);
        ce <= 1'b1;
        repeat (SPAN + 5) @(posedge mclk);
        check({busy, rseq}, {1'b0, 2'h1});
        wb(1'b0, OFS_CTRL, 32'h0);
        check(rd, ctrl_w(1'b0, 1'b1, 2'h1, 3'h5));
        wb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wb(1'b1, OFS_CMD, cmds[i]);
            repeat (2) @(posedge mclk);
            check(host, i == 0);
        end
        wb(1'b1, OFS_CTRL, ctrl_w(1'b0, 1'b0, 2'h0, 3'h6));
        wb(1'b0, OFS_CTRL, 32'h0);
        check(rd[6:2], {3'h5, 2'h1});
        sq = 2'($urandom_range(3, 1));
        for (int b = 0; b < 6; b++)
        begin
            wb(1'b1, OFS_CTRL, ctrl_w(1'b0, 1'b0, sq, 3'(b)));
            wb(1'b0, OFS_CTRL, 32'h0);
            check(rd, ctrl_w(1'b0, 1'b0, sq, 3'(b)));
        end
        wb(1'b1, OFS_CMD, 32'h1);
        repeat (5) @(posedge mclk);
        check({busy, rseq}, {1'b0, sq});
        do_reset(1'b0);
        wb(1'b0, OFS_CTRL, 32'h0);
        check(rd, ctrl_w(1'b0, 1'b0, sq, 3'h5));
        for (int i = 0; i < 2; i++)
        begin
            st = (i == 1) ? 4'($urandom_range(15, 9)) : 4'h7;
            wb(1'b1, OFS_FLD, {28'h0, st});
            send_rec(0);
            repeat (10) @(posedge mclk);
            wb(1'b0, OFS_STAT, 32'h0);
            check({rd[SR_DROP], rd[SR_BUSY], txd}, 3'b101);
            wb(1'b1, OFS_STAT, 32'h10);
            wb(1'b0, OFS_STAT, 32'h0);
            check(rd[SR_DROP], 1'b0);
        end
        check(32'(rxq.size()), 32'h0);
        d = $urandom_range(9, 0);
        wb(1'b1, OFS_FLD + 8'h04, {28'hCCCCCCC, 4'(d)});
        wb(1'b1, OFS_FLD, 32'h5);
        send_rec(3);
        check({rxq[0], rxq[1], rxq[2]}, {8'h35, 8'h0D, 8'h0A});
        check({ana, ferr}, {4'h5, 1'b0});
        repeat (BITC) @(posedge mclk);
        st = ok_st[$urandom_range(5, 0)];
        wb(1'b1, OFS_FLD, {28'h0, st});
        send_rec(3);
        check({rxq[0], rxq[1], rxq[2]}, {4'h3, st, 8'h20, 4'h3, 4'(d)});
        check(ana, st);
        report_and_stop();
    end

    // Cuts a hang short; the whole run needs about 1300 cycles.
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
